// ### bench/rcd_host_model.sv
// Host side that latches input data words on each update
`timescale 1ns/100ps
`default_nettype none
module rcd_host_model (
   input wire logic ref_clk,
   input wire logic dataUpdate,
   input wire logic [3:0] overRangeFlags,
   input wire logic [3:0] underRangeFlags,
   input wire logic [3:0] openFlags,
   output logic [11:0] dataWords
);
   // Range word and broken input word, taken only on update
   always @(posedge ref_clk) begin
      if (dataUpdate) dataWords <= {overRangeFlags, underRangeFlags, openFlags};
   end
endmodule // rcd_host_model
`default_nettype wire

// ### bench/rcd_props.sv
// Checker for the channel diagnostics block
`timescale 1ns/100ps
`default_nettype none
module rcd_props (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic powerGood,
   input wire logic [3:0] chanEnable,
   input wire logic [63:0] chanCfg,
   input wire logic cfgWrite,
   input wire logic calDone,
   input wire logic leadCompDone,
   input wire logic calRequest,
   input wire logic statusLed,
   input wire logic [15:0] errorWord,
   input wire logic [3:0] underRangeFlags,
   input wire logic dataUpdate,
   input wire logic [63:0] activeCfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // A filter or format field above five
   function automatic logic bad(input logic [63:0] c);
      bad = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (c[16*i+:3] > 3'h5 || c[16*i+4+:3] > 3'h5) bad = 1'b1;
      end
   endfunction
   // Startup finish seen since reset; a later power dip does not clear it,
   // since the block only restarts its wait after seeing power drop
   logic calSeen_q;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) calSeen_q <= 1'b0;
      else if (calDone && leadCompDone) calSeen_q <= 1'b1;
   end
   a_led_ok: assert property (statusLed |-> errorWord[11:9] != 3'h1)
      else $error("led on with hardware fault");
   a_class_legal: assert property (errorWord[11:9] < 3'h3 && errorWord[15:12] == 4'h0)
      else $error("bad error class");
   a_ext_clear: assert property (errorWord[11:9] == 3'h0 |-> errorWord[8:0] == 9'h0)
      else $error("extended code without class");
   a_hw_sticky: assert property (errorWord[11:9] == 3'h1 |=> errorWord[11:9] == 3'h1)
      else $error("hardware error lost");
   a_no_under_res: assert property (dataUpdate |-> (underRangeFlags & $past({activeCfg[56],
      activeCfg[40], activeCfg[24], activeCfg[8]})) == 4'h0) else $error("under on resistance");
   a_hold_startup: assert property (dataUpdate |-> calSeen_q)
      else $error("update during startup");
   a_bad_cfg_kept: assert property (cfgWrite && bad(chanCfg) |=> $stable(activeCfg))
      else $error("bad config accepted");
   a_good_cfg_taken: assert property (cfgWrite && !bad(chanCfg) |=> activeCfg == $past(chanCfg))
      else $error("good config lost");
   a_cfg_err_class: assert property (cfgWrite && bad(chanCfg) && errorWord[11:9] != 3'h1
      |-> ##2 errorWord[11:9] == 3'h2) else $error("config error missing");
   a_power_cal: assert property ($rose(powerGood) && chanEnable != 4'h0 |-> ##[1:6] calRequest)
      else $error("no calibration after power");
   c_update: cover property (dataUpdate);
   c_cfg_err: cover property (errorWord[11:9] == 3'h2);
   c_cal: cover property (calRequest);
endmodule // rcd_props
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the channel diagnostics block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic refClk = 1'b0, rstB = 1'b0, pwr = 1'b1, tDone = 1'b1, tPass = 1'b1;
   logic cfgWr = 1'b0, perEn = 1'b0, cDone = 1'b0, lDone = 1'b0, scan = 1'b0;
   logic [3:0] en = 4'h0, ovr = 4'h0, und = 4'h0, opn = 4'h0, sht = 4'h0;
   logic [63:0] cfg = 64'h0;
   wire logic calReq, led, upd;
   wire logic [15:0] err;
   wire logic [3:0] ovF, unF, opF, inv;
   wire logic [63:0] act;
   wire logic [11:0] words;
   int n_fail = 0, checked = 0;
   // Pins over, under, open, short, then expected over, under, broken
   logic [27:0] rows [4] = '{28'h0, 28'h5a00520, 28'h0034007, 28'h0};
   always #25 refClk = ~refClk;
   rcd_channel_diag #(.RECAL_CYCLES(33'h64)) rcd_channel_diag_i (.ref_clk(refClk),
      .rst_b(rstB), .powerGood(pwr), .selfTestDone(tDone), .selfTestPass(tPass),
      .chanEnable(en), .chanCfg(cfg), .cfgWrite(cfgWr), .periodicCalEn(perEn),
      .calDone(cDone), .leadCompDone(lDone), .scanStrobe(scan), .overRange(ovr),
      .underRange(und), .openInput(opn), .shortInput(sht), .calRequest(calReq),
      .statusLed(led), .errorWord(err), .overRangeFlags(ovF), .underRangeFlags(unF),
      .channel_open_input_flags(opF), .channel_data_invalid_bits(inv), .dataUpdate(upd),
      .activeCfg(act));
   rcd_host_model rcd_host_model_i (.ref_clk(refClk), .dataUpdate(upd),
      .overRangeFlags(ovF), .underRangeFlags(unF), .openFlags(opF), .dataWords(words));
   task automatic chk(input string nm, input logic [63:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge refClk);
   endtask
   // Bounded wait for calibration request or data update
   task automatic waitHi(input bit selCal, input int n, input bit want);
      int k = 0;
      while (k < n && (selCal ? calReq : upd) !== 1'b1) begin
         @(posedge refClk);
         #1;
         k++;
      end
      chk(selCal ? "calRequest" : "dataUpdate", {63'h0, want}, {63'h0, k < n});
      if (want && k >= n) print_verdict;
   endtask
   task automatic doScan(input logic [27:0] r, input bit want);
      @(negedge refClk);
      {ovr, und, opn, sht} = r[27:12];
      cyc(2);
      scan = 1'b1;
      waitHi(1'b0, 12, want);
      @(negedge refClk);
      scan = 1'b0;
      cyc(4);
   endtask
   task automatic wrCfg(input logic [63:0] c);
      @(negedge refClk);
      cfg = c;
      cfgWr = 1'b1;
      @(negedge refClk);
      cfgWr = 1'b0;
      cyc(3);
   endtask
   initial begin
      cyc(16);
      chk("invalidBits", 64'hf, inv);
      rstB = 1'b1;
      cyc(2);
      en = 4'hf;
      waitHi(1'b1, 20, 1'b1);
      wrCfg(64'h0100_0000_0000_0000);
      chk("activeCfg", 64'h0100_0000_0000_0000, act);
      doScan(28'h0, 1'b0);
      chk("invalidBits", 64'hf, inv);
      cDone = 1'b1;
      lDone = 1'b1;
      cyc(4);
      chk("statusLed", 64'h1, led);
      foreach (rows[i]) begin
         doScan(rows[i], 1'b1);
         chk("hostWords", {52'h0, rows[i][11:0]}, {52'h0, words});
      end
      chk("errorWord", 64'h0, {48'h0, err});
      chk("invalidBits", 64'h0, inv);
      for (int c = 0; c < 8; c++) begin
         wrCfg(64'h6 << (16 * (c % 4) + 4 * (c / 4)));
         chk("errorWord", 64'h400 + c + 1, {48'h0, err});
         chk("activeCfg", 64'h0100_0000_0000_0000, act);
      end
      perEn = 1'b1;
      waitHi(1'b1, 150, 1'b1);
      @(negedge refClk);
      perEn = 1'b0;
      pwr = 1'b0;
      cyc(4);
      chk("statusLed", 64'h0, led);
      pwr = 1'b1;
      waitHi(1'b1, 10, 1'b1);
      @(negedge refClk);
      rstB = 1'b0;
      tDone = 1'b0;
      tPass = 1'b0;
      cyc(2);
      rstB = 1'b1;
      tDone = 1'b1;
      cyc(6);
      chk("errorWord", 64'h300, {48'h0, err});
      chk("statusLed", 64'h0, led);
      print_verdict;
   end
endmodule // tb_top
bind rcd_channel_diag rcd_props rcd_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .powerGood(powerGood), .chanEnable(chanEnable), .chanCfg(chanCfg), .cfgWrite(cfgWrite),
   .calDone(calDone), .leadCompDone(leadCompDone), .calRequest(calRequest),
   .statusLed(statusLed), .errorWord(errorWord), .underRangeFlags(underRangeFlags),
   .dataUpdate(dataUpdate), .activeCfg(activeCfg));
`default_nettype wire

// ### hdl/rcd_channel_diag.v
// Diagnostics and status reporting for a four-channel resistance input module
`timescale 1ns/100ps
`default_nettype none
`include "rcd_defines.vh"

// Behaviour
// R1: Autocalibrate on new channel, power cycle, periodic.
// R2: Status light only when powered and tests passed.
// R3: Failed self-test: light off, hardware error reported.
// R4: Check configuration when a channel is enabled.
// R5: Every scan check config, range, broken input.
// R6: Report configuration error for improper configuration word.
// R7: Out-of-range sets over/under flag in word five.
// R8: Direct resistance channels never flag under-range.
// R9: Open or short sets broken flag in word four.
// R10: Range errors go to data table, not error.
// R11: Configuration errors give extended error code.
// R12: Hardware and configuration errors reported to host.
// R13: Module error shown on status light immediately.
// R14: Error class in bits 11:9, 000/001/010.
// R15: Bad configuration discarded, previous one kept.
// R16: Data invalid and frozen until startup calibration done.
// R17: Flags clear on first scan without condition.
module rcd_channel_diag #(
   parameter NCH = 4,
   parameter CFGW = 16,
   parameter [32:0] RECAL_CYCLES = `RCD_RECAL_CYC
) (
   input wire ref_clk,
   input wire rst_b,
   input wire powerGood,
   input wire selfTestDone,
   input wire selfTestPass,
   input wire [NCH-1:0] chanEnable,
   input wire [NCH*CFGW-1:0] chanCfg,
   input wire cfgWrite,
   input wire periodicCalEn,
   input wire calDone,
   input wire leadCompDone,
   input wire scanStrobe,
   input wire [NCH-1:0] overRange,
   input wire [NCH-1:0] underRange,
   input wire [NCH-1:0] openInput,
   input wire [NCH-1:0] shortInput,
   output reg calRequest,
   output reg statusLed,
   output reg [15:0] errorWord,
   output reg [NCH-1:0] overRangeFlags,
   output reg [NCH-1:0] underRangeFlags,
   output reg [NCH-1:0] channel_open_input_flags,
   output reg [NCH-1:0] channel_data_invalid_bits,
   output reg dataUpdate,
   output reg [NCH*CFGW-1:0] activeCfg
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [3:0] syncA_q; // First stage, read only by second
reg [3:0] sync_q; // Power, test done, pass, scan
reg [NCH*4-1:0] condA_q; // First stage for channel conditions
reg [NCH*4-1:0] cond_q; // Over, under, open, short
// Two stages for power, self-test, scan and channel condition pins
// Channel pins and scan share one latency, so flags match their scan
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      syncA_q <= 4'h0;
      sync_q <= 4'h0;
      condA_q <= {NCH*4{1'b0}};
      cond_q <= {NCH*4{1'b0}};
   end else begin
      syncA_q <= {powerGood, selfTestDone, selfTestPass, scanStrobe};
      sync_q <= syncA_q;
      condA_q <= {overRange, underRange, openInput, shortInput};
      cond_q <= condA_q;
   end
end
wire pwrS = sync_q[3];
wire testDoneS = sync_q[2];
wire testPassS = sync_q[1];
wire scanS = sync_q[0];
wire [NCH-1:0] ovrS = cond_q[NCH*4-1 -: NCH];
wire [NCH-1:0] undS = cond_q[NCH*3-1 -: NCH];
wire [NCH-1:0] opnS = cond_q[NCH*2-1 -: NCH];
wire [NCH-1:0] shtS = cond_q[NCH-1:0];
reg scanPrev_q; // Scan edge detect
wire scanTick = scanS & ~scanPrev_q;

// ----------------------------------------
// Configuration checks
// ----------------------------------------
reg cfgBad; // Any written word invalid
reg [8:0] cfgCode; // Extended code of first bad field
reg [NCH-1:0] curBad; // Active word invalid per channel
integer i;
// Filter and format field range checks
// Loop runs from the top channel down, so the lowest channel's code
// is the one left; filter is tested after format so filter wins
always @* begin
   cfgBad = 1'b0;
   cfgCode = `RCD_EXT_NONE;
   curBad = {NCH{1'b0}};
   for (i = NCH-1; i >= 0; i = i - 1) begin
      if (chanCfg[i*CFGW+`RCD_CFG_FMT_LSB +: 3] > `RCD_CFG_FMT_MAX) begin
         cfgBad = 1'b1; // R6
         cfgCode = `RCD_EXT_FORMAT0 + i[8:0]; // R11
      end
      if (chanCfg[i*CFGW+`RCD_CFG_FILT_LSB +: 3] > `RCD_CFG_FILT_MAX) begin
         cfgBad = 1'b1; // R6
         cfgCode = `RCD_EXT_FILTER0 + i[8:0]; // R11
      end
      if (chanEnable[i] &&
          (activeCfg[i*CFGW+`RCD_CFG_FMT_LSB +: 3] > `RCD_CFG_FMT_MAX ||
           activeCfg[i*CFGW+`RCD_CFG_FILT_LSB +: 3] > `RCD_CFG_FILT_MAX))
         curBad[i] = 1'b1; // R4 R5
   end
end

// ----------------------------------------
// Module state: self-test, config, errors
// ----------------------------------------
reg testFail_q; // Latched self-test failure
reg cfgErr_q; // Latched configuration error
reg [8:0] cfgCode_q; // Code of latched configuration error
reg [NCH-1:0] enPrev_q; // Enables last cycle
reg [NCH-1:0] seen_q; // Channels enabled before
reg pwrPrev_q; // Power last cycle
// Five minutes at 20 MHz needs 33 bits; a 32-bit timer would wrap early
reg [32:0] recalCnt_q; // Periodic calibration timer
reg startup_q; // Startup calibration in progress
wire hwErr = (testDoneS & ~testPassS) | testFail_q;
// A channel counts as new only on its first enable since reset
wire [NCH-1:0] newChan = chanEnable & ~enPrev_q & ~seen_q;
wire pwrUp = pwrS & ~pwrPrev_q;
wire recalTick = periodicCalEn && (recalCnt_q >= RECAL_CYCLES - 33'h1);
// Sequential state
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      testFail_q <= 1'b0;
      cfgErr_q <= 1'b0;
      cfgCode_q <= `RCD_EXT_NONE;
      enPrev_q <= {NCH{1'b0}};
      seen_q <= {NCH{1'b0}};
      pwrPrev_q <= 1'b0;
      scanPrev_q <= 1'b0;
      recalCnt_q <= 33'h0;
      startup_q <= 1'b1;
      calRequest <= 1'b0;
      activeCfg <= {NCH*CFGW{1'b0}};
   end else begin
      scanPrev_q <= scanS;
      pwrPrev_q <= pwrS;
      enPrev_q <= chanEnable;
      seen_q <= seen_q | chanEnable;
      if (testDoneS && !testPassS)
         testFail_q <= 1'b1; // R3
      if (cfgWrite) begin
         if (cfgBad) begin
            cfgErr_q <= 1'b1; // R15
            cfgCode_q <= cfgCode; // R11
         end else begin
            activeCfg <= chanCfg; // R15
            cfgErr_q <= 1'b0;
            cfgCode_q <= `RCD_EXT_NONE;
         end
      end else if (scanTick && |curBad) begin
         cfgErr_q <= 1'b1; // R5 R6
      end
      // Periodic timer only runs while enabled
      if (!periodicCalEn || recalTick)
         recalCnt_q <= 33'h0;
      else
         recalCnt_q <= recalCnt_q + 33'h1;
      // High for one cycle after each cycle with any cause; each cause is a one-cycle edge or timer wrap, so a held enable or power does not keep it high
      calRequest <= (|newChan) | (pwrUp & (|chanEnable)) | recalTick; // R1
      // Loss of power restarts the startup calibration wait
      if (!pwrS)
         startup_q <= 1'b1; // R16
      else if (calDone && leadCompDone)
         startup_q <= 1'b0; // R16
   end
end

// ----------------------------------------
// Outputs: light, error word, channel flags
// ----------------------------------------
integer c;
// Reported state
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      statusLed <= 1'b0;
      errorWord <= 16'h0000;
      overRangeFlags <= {NCH{1'b0}};
      underRangeFlags <= {NCH{1'b0}};
      channel_open_input_flags <= {NCH{1'b0}};
      channel_data_invalid_bits <= {NCH{1'b1}};
      dataUpdate <= 1'b0;
   end else begin
      statusLed <= pwrS & testDoneS & testPassS & ~hwErr; // R2 R13
      // Hardware class outranks configuration class
      if (hwErr)
         errorWord <= {4'h0, `RCD_ERR_HW, `RCD_EXT_SELFTEST}; // R12 R14
      else if (cfgErr_q)
         errorWord <= {4'h0, `RCD_ERR_CFG, cfgCode_q}; // R12 R14
      else
         errorWord <= {4'h0, `RCD_ERR_NONE, `RCD_EXT_NONE}; // R10 R14
      dataUpdate <= scanTick & ~startup_q; // R16
      if (startup_q) begin
         channel_data_invalid_bits <= {NCH{1'b1}}; // R16
      end else if (scanTick) begin
         // Every flag is rewritten each scan, so a cleared cause clears it
         for (c = 0; c < NCH; c = c + 1) begin
            channel_data_invalid_bits[c] <= ~chanEnable[c] | curBad[c];
            overRangeFlags[c] <= chanEnable[c] & ovrS[c]; // R7 R17
            underRangeFlags[c] <= chanEnable[c] & undS[c] &
               ~activeCfg[c*CFGW+`RCD_CFG_RES_BIT]; // R8 R17
            channel_open_input_flags[c] <= chanEnable[c] & (opnS[c] | shtS[c]); // R9 R17
         end
      end
   end
end

endmodule // rcd_channel_diag
`default_nettype wire

// ### hdl/rcd_defines.vh
// Constants shared by the sensor channel diagnostics block
`ifndef RCD_DEFINES_VH
`define RCD_DEFINES_VH
// ----------------------------------------
// Timing
// ----------------------------------------
// Clock rate of 20 MHz; all 33 bits wide so the five-minute count fits
`define RCD_CLK_HZ 33'h1312d00
`define RCD_RECAL_MIN 33'h5
`define RCD_SEC_PER_MIN 33'h3c
`define RCD_RECAL_CYC (`RCD_RECAL_MIN * `RCD_SEC_PER_MIN * `RCD_CLK_HZ)
// ----------------------------------------
// Error word layout
// ----------------------------------------
`define RCD_ERR_NONE 3'h0
`define RCD_ERR_HW 3'h1
`define RCD_ERR_CFG 3'h2
`define RCD_EXT_NONE 9'h000
`define RCD_EXT_SELFTEST 9'h100
`define RCD_EXT_FILTER0 9'h001
`define RCD_EXT_FORMAT0 9'h005
// ----------------------------------------
// Channel configuration word fields
// ----------------------------------------
`define RCD_CFG_FILT_LSB 0
`define RCD_CFG_FILT_MAX 3'h5
`define RCD_CFG_FMT_LSB 4
`define RCD_CFG_FMT_MAX 3'h5
`define RCD_CFG_RES_BIT 8
`endif
